// ### hw/clock_select_top.sv
// Main clock source selector, protected settings and clock gates.
// Assumes pins are sampled on the bus clock.
//
// Notes on behaviour
// - Source code 00/01/10 picks 8M/128k/external.
// - All synchronous clocks come from main clock.
// - Source switch at run time without glitch.
// - Reset picks 8 MHz source, divide by 8.
// - Reset loads factory calibration into trim.
// - Watchdog clock always from 128 kHz oscillator.
// - Prescaler serves every source, clocks all but the watchdog.
// - Divider change never shortens any period.
// - Ripple counter count is hidden from software.
// - New rate active from the next system clock rise.
// - Core clock halts the core when stopped.
// - Peripheral clock gated; async interrupt still seen.
// - Memory controller clock gated with core clock.
// - Converter clock runs while others stop.
// - Sleep control can gate unused clock domains.
// - Divider codes 0..8 give 1..256, reset 3.
// - Protected writes only within four instruction cycles.
// - Only signature D8 unlocks protected registers.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module clock_select_top (
    input wire logic aclk, // Bus clock, 200 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [clk_ctrl_pkg::ADDR_W-1:0] awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [clk_ctrl_pkg::ADDR_W-1:0] araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    input wire logic osc8_in, // Fast oscillator.
    input wire logic osc128_in, // Slow oscillator.
    input wire logic external_clock_input, // External clock pin.
    input wire logic ext_int_pin, // Interrupt pin.
    input wire logic [7:0] factory_cal_byte, // Calibration byte.
    input wire logic core_stop, // Core halt.
    input wire logic io_stop, // Peripheral halt.
    input wire logic adc_stop, // Converter halt.
    output logic main_clock, // Selected main clock.
    output logic core_clock, // Core clock domain.
    output logic peripheral_clock, // Peripheral clock domain.
    output logic nonvolatile_ctrl_clock, // Memory controller clock.
    output logic converter_clock, // Converter clock domain.
    output logic watchdog_clock, // Watchdog clock.
    output logic [7:0] trim_out, // Trim value to the oscillator.
    output logic ext_int_level // Interrupt level.
);
    import clk_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_in;
    logic [SYNC_STAGES-1:0] sync_ff [NUM_PINS];
    logic [NUM_PINS-1:0] lvl_ff;

    assign pin_in = {ext_int_pin, external_clock_input, osc128_in, osc8_in};

    // Three flops; stages two and three must agree.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++)
        begin : g_sync
            logic nxt_lvl;
            always_comb
            begin
                nxt_lvl = (sync_ff[gi][1] == sync_ff[gi][2]) ? sync_ff[gi][2] : lvl_ff[gi];
            end
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    sync_ff[gi] <= 3'h0;
                    lvl_ff[gi] <= 1'b0;
                end
                else
                begin
                    sync_ff[gi] <= {sync_ff[gi][1:0], pin_in[gi]};
                    lvl_ff[gi] <= nxt_lvl;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------
    logic aw_hold_ff;
    logic nxt_aw_hold;
    logic w_hold_ff;
    logic nxt_w_hold;
    logic [5:0] widx_ff;
    logic [5:0] nxt_widx;
    logic [7:0] wbyte_ff;
    logic [7:0] nxt_wbyte;
    logic wlane_ff;
    logic nxt_wlane;
    logic awready_ff;
    logic nxt_awready;
    logic wready_ff;
    logic nxt_wready;
    logic bvalid_ff;
    logic nxt_bvalid;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;
    logic arready_ff;
    logic nxt_arready;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;
    logic do_write;
    logic [5:0] ridx;

    // ------------------------------------------------------------
    // Register and clock state
    // ------------------------------------------------------------
    logic [1:0] src_sel_ff;
    logic [1:0] nxt_src_sel;
    logic [3:0] div_sel_ff;
    logic [3:0] nxt_div_sel;
    logic [7:0] trim_ff;
    logic [7:0] nxt_trim;
    logic [2:0] unlock_ff;
    logic [2:0] nxt_unlock;
    switch_state_e sw_ff;
    switch_state_e nxt_sw;
    logic [1:0] cur_src_ff;
    logic [1:0] nxt_cur_src;
    logic [1:0] tgt_ff;
    logic [1:0] nxt_tgt;
    logic main_ff;
    logic nxt_main;
    logic main_rise_ff;
    logic nxt_main_rise;
    logic cur_lvl;
    logic tgt_lvl;
    logic core_gate_ff;
    logic nxt_core_gate;
    logic io_gate_ff;
    logic nxt_io_gate;
    logic adc_gate_ff;
    logic nxt_adc_gate;
    logic core_clk_ff;
    logic io_clk_ff;
    logic nvm_clk_ff;
    logic adc_clk_ff;
    logic wdt_clk_ff;

    prescale_if pif ();

    // Level of a source; code 11 yields none.
    function automatic logic src_level(input logic [1:0] src, input logic [NUM_PINS-1:0] lv);
        logic res;
        res = 1'b0;
        unique case (src)
            SRC_OSC8: res = lv[PIN_OSC8];
            SRC_OSC128: res = lv[PIN_OSC128];
            SRC_EXT: res = lv[PIN_EXT];
            SRC_RESERVED: res = 1'b0;
        endcase
        return res;
    endfunction : src_level

    // True where an index holds a register.
    function automatic logic mapped(input logic [5:0] idx);
        return (idx == IDX_DIVIDER) || (idx == IDX_SETTINGS) || (idx == IDX_TRIM)
            || (idx == IDX_PROTECT) || (idx == IDX_STATUS);
    endfunction : mapped

    // ------------------------------------------------------------
    // AXI4-Lite write and read channels
    // ------------------------------------------------------------
    // Address and data are held; the write runs once both are in.
    always_comb
    begin
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold = w_hold_ff;
        nxt_widx = widx_ff;
        nxt_wbyte = wbyte_ff;
        nxt_wlane = wlane_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        do_write = 1'b0;
        if (awvalid && awready_ff)
        begin
            nxt_aw_hold = 1'b1;
            nxt_widx = awaddr[7:2];
        end
        if (wvalid && wready_ff)
        begin
            nxt_w_hold = 1'b1;
            nxt_wbyte = wdata[7:0];
            nxt_wlane = wstrb[0];
        end
        if (bvalid_ff && bready)
        begin
            nxt_bvalid = 1'b0;
        end
        if (aw_hold_ff && w_hold_ff && !bvalid_ff)
        begin
            do_write = 1'b1;
            nxt_aw_hold = 1'b0;
            nxt_w_hold = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = mapped(widx_ff) ? RESP_OKAY : RESP_SLVERR;
        end
        nxt_awready = !nxt_aw_hold && !nxt_bvalid;
        nxt_wready = !nxt_w_hold && !nxt_bvalid;
    end

    // Read answer a cycle after the address.
    always_comb
    begin
        ridx = araddr[7:2];
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && rready)
        begin
            nxt_rvalid = 1'b0;
        end
        if (arvalid && arready_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
            nxt_rdata = 32'h0000_0000;
            unique case (1'b1)
                ridx == IDX_DIVIDER: nxt_rdata[3:0] = div_sel_ff;
                ridx == IDX_SETTINGS: nxt_rdata[1:0] = src_sel_ff;
                ridx == IDX_TRIM: nxt_rdata[7:0] = trim_ff;
                ridx == IDX_PROTECT: nxt_rdata[0] = (unlock_ff != 3'h0);
                ridx == IDX_STATUS: nxt_rdata[7:0] = {pif.act_div, 1'b0, sw_ff, cur_src_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        nxt_arready = !nxt_rvalid;
    end

    // Registers of the bus slave.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            widx_ff <= 6'h00;
            wbyte_ff <= 8'h00;
            wlane_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end
        else
        begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            widx_ff <= nxt_widx;
            wbyte_ff <= nxt_wbyte;
            wlane_ff <= nxt_wlane;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // ------------------------------------------------------------
    // Protected settings and trim register
    // ------------------------------------------------------------
    // The window counts system clock rises as instruction cycles.
    always_comb
    begin
        nxt_src_sel = src_sel_ff;
        nxt_div_sel = div_sel_ff;
        nxt_trim = trim_ff;
        nxt_unlock = unlock_ff;
        if (pif.sys_rise && unlock_ff != 3'h0)
        begin
            nxt_unlock = unlock_ff - 3'h1;
        end
        if (do_write && wlane_ff)
        begin
            if (widx_ff == IDX_PROTECT && wbyte_ff == SIGNATURE)
            begin
                nxt_unlock = UNLOCK_CYCLES;
            end
            if (widx_ff == IDX_SETTINGS && unlock_ff != 3'h0 && wbyte_ff[1:0] != SRC_RESERVED)
            begin
                nxt_src_sel = wbyte_ff[1:0];
            end
            if (widx_ff == IDX_DIVIDER && unlock_ff != 3'h0 && wbyte_ff[3:0] <= DIV_MAX)
            begin
                nxt_div_sel = wbyte_ff[3:0];
            end
            if (widx_ff == IDX_TRIM)
            begin
                nxt_trim = wbyte_ff;
            end
        end
    end

    // Settings; trim takes the stored byte in reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_sel_ff <= SRC_RESET;
            div_sel_ff <= DIV_RESET;
            trim_ff <= factory_cal_byte;
            unlock_ff <= 3'h0;
        end
        else
        begin
            src_sel_ff <= nxt_src_sel;
            div_sel_ff <= nxt_div_sel;
            trim_ff <= nxt_trim;
            unlock_ff <= nxt_unlock;
        end
    end

    // ------------------------------------------------------------
    // Glitch-free main clock source switch
    // ------------------------------------------------------------
    // Park low once the old source is low, then resume on the
    // new source while it is low, so no runt pulse appears.
    always_comb
    begin
        cur_lvl = src_level(cur_src_ff, lvl_ff);
        tgt_lvl = src_level(tgt_ff, lvl_ff);
        nxt_sw = sw_ff;
        nxt_cur_src = cur_src_ff;
        nxt_tgt = tgt_ff;
        nxt_main = main_ff;
        unique case (sw_ff)
            SW_RUN:
            begin
                nxt_main = cur_lvl;
                if (src_sel_ff != cur_src_ff && !cur_lvl && !main_ff)
                begin
                    nxt_sw = SW_PARK;
                    nxt_tgt = src_sel_ff;
                    nxt_main = 1'b0;
                end
            end
            SW_PARK:
            begin
                nxt_main = 1'b0;
                if (!tgt_lvl)
                begin
                    nxt_sw = SW_RUN;
                    nxt_cur_src = tgt_ff;
                end
            end
        endcase
        nxt_main_rise = nxt_main && !main_ff;
    end

    // Registers of the source switch.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_ff <= SW_RUN;
            cur_src_ff <= SRC_RESET;
            tgt_ff <= SRC_RESET;
            main_ff <= 1'b0;
            main_rise_ff <= 1'b0;
        end
        else
        begin
            sw_ff <= nxt_sw;
            cur_src_ff <= nxt_cur_src;
            tgt_ff <= nxt_tgt;
            main_ff <= nxt_main;
            main_rise_ff <= nxt_main_rise;
        end
    end

    // Prescaler fed from main clock only.
    assign pif.main_lvl = main_ff;
    assign pif.main_rise = main_rise_ff;
    assign pif.div_sel = div_sel_ff;

    sys_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .pif(pif.presc)
    );

    // ------------------------------------------------------------
    // Clock domain gates
    // ------------------------------------------------------------
    // Gates change only while the system clock is low.
    always_comb
    begin
        nxt_core_gate = pif.sys_clk ? core_gate_ff : !core_stop;
        nxt_io_gate = pif.sys_clk ? io_gate_ff : !io_stop;
        nxt_adc_gate = pif.sys_clk ? adc_gate_ff : !adc_stop;
    end

    // Gated domain clocks from the system clock.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_gate_ff <= 1'b1;
            io_gate_ff <= 1'b1;
            adc_gate_ff <= 1'b1;
            core_clk_ff <= 1'b0;
            io_clk_ff <= 1'b0;
            nvm_clk_ff <= 1'b0;
            adc_clk_ff <= 1'b0;
            wdt_clk_ff <= 1'b0;
        end
        else
        begin
            core_gate_ff <= nxt_core_gate;
            io_gate_ff <= nxt_io_gate;
            adc_gate_ff <= nxt_adc_gate;
            core_clk_ff <= pif.sys_clk && core_gate_ff;
            io_clk_ff <= pif.sys_clk && io_gate_ff;
            nvm_clk_ff <= pif.sys_clk && core_gate_ff;
            adc_clk_ff <= pif.sys_clk && adc_gate_ff;
            wdt_clk_ff <= lvl_ff[PIN_OSC128];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a flop.
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign main_clock = main_ff;
    assign core_clock = core_clk_ff;
    assign peripheral_clock = io_clk_ff;
    assign nonvolatile_ctrl_clock = nvm_clk_ff;
    assign converter_clock = adc_clk_ff;
    assign watchdog_clock = wdt_clk_ff;
    assign trim_out = trim_ff;
    assign ext_int_level = lvl_ff[PIN_XINT];

endmodule : clock_select_top

// ### hw/clk_ctrl_pkg.sv
// Constants and types of the clock select block.
// Assumes AXI4-Lite access with 32-bit data.
package clk_ctrl_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_DIVIDER = 6'h36;
    localparam logic [5:0] IDX_SETTINGS = 6'h37;
    localparam logic [5:0] IDX_TRIM = 6'h39;
    localparam logic [5:0] IDX_PROTECT = 6'h3C;
    localparam logic [5:0] IDX_STATUS = 6'h30;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // Field values and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SIGNATURE = 8'hD8;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam logic [1:0] SRC_OSC8 = 2'h0;
    localparam logic [1:0] SRC_OSC128 = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;
    localparam logic [1:0] SRC_RESET = SRC_OSC8;
    localparam logic [3:0] DIV_RESET = 4'h3;
    localparam logic [3:0] DIV_MAX = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NUM_PINS = 4;
    localparam int SYNC_STAGES = 3;
    localparam int PIN_OSC8 = 0;
    localparam int PIN_OSC128 = 1;
    localparam int PIN_EXT = 2;
    localparam int PIN_XINT = 3;

    // Source switch: follow or park low.
    typedef enum logic {SW_RUN = 1'b0, SW_PARK = 1'b1} switch_state_e;

endpackage : clk_ctrl_pkg

// ### hw/prescale_if.sv
// Selector to prescaler link.
// Assumes one bus clock.
`timescale 1ns/1ps
interface prescale_if;
    logic main_lvl;
    logic main_rise;
    logic [3:0] div_sel;
    logic sys_clk;
    logic sys_rise;
    logic [3:0] act_div;
    modport ctrl (output main_lvl, output main_rise, output div_sel,
                  input sys_clk, input sys_rise, input act_div);
    modport presc (input main_lvl, input main_rise, input div_sel,
                   output sys_clk, output sys_rise, output act_div);
endinterface : prescale_if

// ### hw/sys_prescaler.sv
// System clock prescaler.
// Assumes main clock events as bus-clock flops.
`timescale 1ns/1ps
module sys_prescaler (
    input wire logic aclk, // Bus clock.
    input wire logic aresetn, // Synchronous reset, active low.
    prescale_if.presc pif // Main clock in, system clock out.
);
    import clk_ctrl_pkg::*;

    logic [3:0] act_ff;
    logic [3:0] nxt_act;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic sys_ff;
    logic nxt_sys;
    logic rise_ff;
    logic nxt_rise;
    logic [7:0] half_len;

    // ------------------------------------------------------------
    // Edge counter and divisor take-over
    // ------------------------------------------------------------
    // The count is hidden from software.
    always_comb
    begin
        half_len = (act_ff == 4'h0) ? 8'h01 : 8'(9'h001 << (act_ff - 4'h1));
        nxt_act = act_ff;
        nxt_cnt = cnt_ff;
        nxt_sys = sys_ff;
        nxt_rise = 1'b0;
        if (act_ff == 4'h0)
        begin
            if (pif.main_rise)
            begin
                nxt_sys = 1'b1;
                nxt_rise = 1'b1;
            end
            else if (!pif.main_lvl)
            begin
                nxt_sys = 1'b0;
            end
        end
        else if (pif.main_rise)
        begin
            if (cnt_ff + 8'h01 >= half_len)
            begin
                nxt_cnt = 8'h00;
                nxt_sys = ~sys_ff;
                nxt_rise = ~sys_ff;
            end
            else
            begin
                nxt_cnt = cnt_ff + 8'h01;
            end
        end
        // A new divisor starts at a rise, so no period is cut.
        if (nxt_rise)
        begin
            nxt_act = pif.div_sel;
            nxt_cnt = 8'h00;
        end
    end

    // Registers of the prescaler.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            act_ff <= DIV_RESET;
            cnt_ff <= 8'h00;
            sys_ff <= 1'b0;
            rise_ff <= 1'b0;
        end
        else
        begin
            act_ff <= nxt_act;
            cnt_ff <= nxt_cnt;
            sys_ff <= nxt_sys;
            rise_ff <= nxt_rise;
        end
    end

    // Outputs to the selector.
    assign pif.sys_clk = sys_ff;
    assign pif.sys_rise = rise_ff;
    assign pif.act_div = act_ff;

endmodule : sys_prescaler

// ### testbench/osc_model.sv
// Oscillators and external clock.
// Assumes the bench clock.
`timescale 1ns/1ps
module osc_model (
    input wire logic aclk, // Bench clock.
    output logic osc8, // Fast oscillator, period 8 cycles.
    output logic osc128, // Slow oscillator, period 32 cycles.
    output logic ext_clk // External clock, period 16 cycles.
);
    logic [4:0] cnt_ff = 5'h00;

    // Free-running count.
    always_ff @(posedge aclk)
    begin
        cnt_ff <= cnt_ff + 5'h01;
    end

    // One count bit each, so no rate step.
    assign osc8 = cnt_ff[2];
    assign osc128 = cnt_ff[4];
    assign ext_clk = cnt_ff[3];
endmodule : osc_model

// ### testbench/clk_ctrl_monitor.sv
// Checker on the top's ports.
// Assumes the bus clock and reset.
`timescale 1ns/1ps
module clk_ctrl_monitor (
    input wire logic aclk, // Bus clock.
    input wire logic aresetn, // Reset, active low.
    input wire logic [7:0] factory_cal_byte, // Calibration byte.
    input wire logic [7:0] trim_out, // Trim value.
    input wire logic main_clock, // Main clock.
    input wire logic core_clock, // Core clock.
    input wire logic nonvolatile_ctrl_clock, // Memory clock.
    input wire logic core_stop, // Core halt request.
    input wire logic watchdog_clock, // Watchdog clock.
    input wire logic osc128_in, // Slow oscillator.
    input wire logic ext_int_pin, // Interrupt pin.
    input wire logic ext_int_level // Interrupt level.
);
    // Bus clock; off in reset.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_trim_load: assert property (disable iff (1'b0)
        !aresetn |=> trim_out == $past(factory_cal_byte)) else $error("Trim not loaded.");
    a_reset_idle: assert property (disable iff (1'b0)
        !aresetn |=> !main_clock && !core_clock) else $error("Clocks run in reset.");
    a_main_glitch: assert property (
        $rose(main_clock) |=> main_clock [*2]) else $error("Main runt.");
    a_core_glitch: assert property (
        $rose(core_clock) |=> core_clock) else $error("Core runt.");
    a_nvm_core: assert property (
        nonvolatile_ctrl_clock == core_clock) else $error("Memory clock apart.");
    a_wdog_follow: assert property (
        $rose(watchdog_clock) |-> $past(osc128_in, 2) && $past(osc128_in, 3)) else $error("Watchdog clock wrong.");
    a_irq_follow: assert property (
        $rose(ext_int_level) |-> $past(ext_int_pin, 2)) else $error("Interrupt level without pin.");
    a_core_halt: assert property (
        core_stop && $past(core_stop) && !core_clock |=> !core_clock) else $error("Core not halted.");

    c_main_rise: cover property ($rose(main_clock));
    c_core_halt: cover property (core_stop && !core_clock);
    c_irq_seen: cover property ($rose(ext_int_level));
endmodule : clk_ctrl_monitor

bind clock_select_top clk_ctrl_monitor mon (.*);

// ### testbench/main_clock_select_and_prescaler_tb.sv
// Bench: bus access and clock periods.
// Assumes the source model.
`timescale 1ns/1ps
module main_clock_select_and_prescaler_tb;
    import clk_ctrl_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, factory_cal_byte = 8'hA5, trim_out;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic ext_int_pin = 0, core_stop = 0, io_stop = 0, adc_stop = 0, external_clock_input;
    logic awready, wready, bvalid, arready, rvalid, main_clock, core_clock, peripheral_clock;
    logic nonvolatile_ctrl_clock, converter_clock, watchdog_clock, ext_int_level, osc8_in, osc128_in;
    logic [1:0] bresp, rresp;
    int n_mismatch = 0, cmp_count = 0, k;
    wire [3:0] clks = {converter_clock, main_clock, core_clock, watchdog_clock};
    localparam logic [7:0] A_DIV = {IDX_DIVIDER, 2'b00}, A_SET = {IDX_SETTINGS, 2'b00};
    localparam logic [7:0] A_TRIM = {IDX_TRIM, 2'b00}, A_PROT = {IDX_PROTECT, 2'b00};

    // 200 MHz clock.
    always #2.5 aclk = ~aclk;

    clock_select_top dut (.*);
    osc_model pm (.aclk(aclk), .osc8(osc8_in), .osc128(osc128_in), .ext_clk(external_clock_input));

    task automatic final_report;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // One bus write or read; a channel drops once taken.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [1:0] er,
                       input logic [7:0] ed);
        int n;
        logic ta, tw, tq, tr;
        tr = 0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'hF;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        for (n = 0; n < 99 && !tr; n++)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tq = arvalid && arready;
            tr = w ? bvalid : rvalid;
            if (tr)
                chk(w ? bresp : rresp, er);
            if (tr && !w && er === RESP_OKAY)
                chk(rdata, {24'h00_0000, ed});
            @(posedge aclk);
            if (ta)
                awvalid <= 0;
            if (tw)
                wvalid <= 0;
            if (tq)
                arvalid <= 0;
            bready <= w && !tr;
            rready <= !w && !tr;
        end
        if (!tr)
        begin
            n_mismatch++;
            final_report();
        end
    endtask : acc

    // Period between second and third rise.
    task automatic per(input int i, input int e);
        int n, r, c;
        logic p;
        r = 0;
        c = 0;
        p = clks[i];
        for (n = 0; n < 9000 && r < 3; n++)
        begin
            @(negedge aclk);
            if (r == 2)
                c++;
            if (clks[i] && !p)
                r++;
            p = clks[i];
        end
        if (r < 3)
        begin
            n_mismatch++;
            final_report();
        end
        chk(32'(c), 32'(e));
    endtask : per

    // Reset values, protection, dividers, sources, gates.
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        acc(0, A_TRIM, 0, RESP_OKAY, 8'hA5);
        acc(0, A_SET, 0, RESP_OKAY, {6'h00, SRC_RESET});
        acc(0, A_DIV, 0, RESP_OKAY, {4'h0, DIV_RESET});
        per(2, 8);
        per(1, 64);
        acc(1, A_DIV, 0, RESP_OKAY, 0);
        acc(0, A_DIV, 0, RESP_OKAY, {4'h0, DIV_RESET});
        acc(1, A_PROT, 8'hD7, RESP_OKAY, 0);
        acc(1, A_DIV, 0, RESP_OKAY, 0);
        acc(0, A_DIV, 0, RESP_OKAY, {4'h0, DIV_RESET});
        for (k = 0; k < 10; k++)
        begin
            acc(1, A_PROT, SIGNATURE, RESP_OKAY, 0);
            acc(1, A_DIV, k[7:0], RESP_OKAY, 0);
            acc(0, A_DIV, 0, RESP_OKAY, k > 8 ? 8'h08 : k[7:0]);
        end
        per(1, 2048);
        acc(1, A_PROT, SIGNATURE, RESP_OKAY, 0);
        acc(0, A_PROT, 0, RESP_OKAY, 8'h01);
        acc(1, A_DIV, 0, RESP_OKAY, 0);
        per(1, 8);
        repeat (40) @(posedge aclk);
        acc(1, A_DIV, 8'h01, RESP_OKAY, 0);
        acc(0, A_DIV, 0, RESP_OKAY, 0);
        for (k = 0; k < 4; k++)
        begin
            acc(1, A_PROT, SIGNATURE, RESP_OKAY, 0);
            acc(1, A_SET, k[7:0], RESP_OKAY, 0);
            acc(0, A_SET, 0, RESP_OKAY, k == 3 ? 8'h02 : k[7:0]);
            per(1, k == 1 ? 32 : k == 0 ? 8 : 16);
        end
        acc(1, A_PROT, SIGNATURE, RESP_OKAY, 0);
        acc(1, A_DIV, 8'h01, RESP_OKAY, 0);
        per(1, 32);
        acc(1, 8'h00, 8'h55, RESP_SLVERR, 0);
        acc(0, 8'h00, 0, RESP_SLVERR, 0);
        core_stop <= 1;
        io_stop <= 1;
        ext_int_pin <= 1;
        per(3, 32);
        chk(ext_int_level, 1);
        chk({peripheral_clock, core_clock, trim_out}, {2'b00, 8'hA5});
        per(0, 32);
        final_report();
    end
endmodule : main_clock_select_and_prescaler_tb
